// >>> sdl_bit_engine.sv
// bit-level timing engine on the debug pin: receive, transmit, timeout, sync pulse
`timescale 1ns/100ps
`default_nettype none
module sdl_bit_engine (
  // clock and reset
  input  wire logic ref_clk_i,
  input  wire logic rst_b_i,
  // debug clock tick and filtered pin
  input  wire logic tick_i,
  input  wire logic pin_lvl_i,
  input  wire logic pin_fall_i,
  input  wire logic pin_rise_i,
  // transmit request for the next bit
  input  wire logic tx_mode_i,
  input  wire logic tx_bit_i,
  // bit events
  output logic      rx_valid_o,
  output logic      rx_bit_o,
  output logic      tx_done_o,
  output logic      timeout_o,
  output logic      sync_o,
  // pin drive
  output logic      pin_o,
  output logic      pin_oe_o
);
  typedef enum logic [2:0] {EN_IDLE, EN_BIT, EN_SWAIT, EN_SDRV, EN_SUP} sdl_eng_st_t;

  sdl_eng_st_t st_reg, st_next;
  logic [9:0]  cnt_reg, cnt_next;
  logic [9:0]  to_reg, to_next;
  logic [7:0]  low_reg, low_next;
  logic        txm_reg, txm_next, txb_reg, txb_next;
  logic        rxv_next, rxb_next, txd_next, to_p_next, sync_next, o_next, oe_next;

  always_comb begin
    st_next   = st_reg;
    cnt_next  = cnt_reg;
    to_next   = to_reg;
    low_next  = low_reg;
    txm_next  = txm_reg;
    txb_next  = txb_reg;
    rxv_next  = 1'b0;
    rxb_next  = rx_bit_o;
    txd_next  = 1'b0;
    to_p_next = 1'b0;
    sync_next = 1'b0;
    o_next    = 1'b0;
    oe_next   = 1'b0;
    if (pin_fall_i) begin
      to_next = '0;
    end else if (tick_i && to_reg < sdl_pkg::TIMEOUT_CYCLES) begin
      to_next = to_reg + 10'h001;
      to_p_next = (to_reg == sdl_pkg::TIMEOUT_CYCLES - 10'h001);
    end
    if (st_reg == EN_SDRV || st_reg == EN_SUP || pin_lvl_i) begin
      low_next = '0;
    end else if (tick_i && low_reg < sdl_pkg::SYNC_LOW_MIN) begin
      low_next = low_reg + 8'h01;
    end
    case (st_reg)
      EN_IDLE, EN_BIT: begin
        if (pin_rise_i && low_reg == sdl_pkg::SYNC_LOW_MIN) begin
          st_next   = EN_SWAIT;
          cnt_next  = '0;
          sync_next = 1'b1;
        end else if (pin_fall_i) begin
          st_next  = EN_BIT;
          cnt_next = '0;
          txm_next = tx_mode_i;
          txb_next = tx_bit_i;
        end else if (st_reg == EN_BIT && tick_i) begin
          cnt_next = cnt_reg + 10'h001;
          if (!txm_reg && cnt_reg == sdl_pkg::RX_SAMPLE - 10'h001) begin
            rxv_next = 1'b1;
            rxb_next = pin_lvl_i;
          end
          if (cnt_reg == sdl_pkg::BIT_CYCLES - 10'h001) begin
            st_next  = EN_IDLE;
            txd_next = txm_reg;
          end
        end
        // host-to-target bits never drive the pin
        if (st_reg == EN_BIT && txm_reg) begin
          if (txb_reg) begin
            o_next  = 1'b1;
            oe_next = (cnt_reg == sdl_pkg::TX1_PULSE);
          end else begin
            o_next  = (cnt_reg == sdl_pkg::TX0_LOW);
            oe_next = (cnt_reg <= sdl_pkg::TX0_LOW);
          end
        end
      end
      EN_SWAIT: if (tick_i) begin
        cnt_next = cnt_reg + 10'h001;
        if (cnt_reg == sdl_pkg::SYNC_DELAY - 10'h001) begin
          st_next  = EN_SDRV;
          cnt_next = '0;
        end
      end
      EN_SDRV: begin
        oe_next = 1'b1;
        if (tick_i) begin
          cnt_next = cnt_reg + 10'h001;
          if (cnt_reg == sdl_pkg::SYNC_PULSE - 10'h001) begin
            st_next = EN_SUP;
          end
        end
      end
      EN_SUP: begin
        o_next  = 1'b1;
        oe_next = 1'b1;
        if (tick_i) begin
          st_next = EN_IDLE;
        end
      end
      default: st_next = EN_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      st_reg     <= EN_IDLE;
      cnt_reg    <= '0;
      to_reg     <= '0;
      low_reg    <= '0;
      txm_reg    <= 1'b0;
      txb_reg    <= 1'b0;
      rx_valid_o <= 1'b0;
      rx_bit_o   <= 1'b0;
      tx_done_o  <= 1'b0;
      timeout_o  <= 1'b0;
      sync_o     <= 1'b0;
      pin_o      <= 1'b0;
      pin_oe_o   <= 1'b0;
    end else begin
      st_reg     <= st_next;
      cnt_reg    <= cnt_next;
      to_reg     <= to_next;
      low_reg    <= low_next;
      txm_reg    <= txm_next;
      txb_reg    <= txb_next;
      rx_valid_o <= rxv_next;
      rx_bit_o   <= rxb_next;
      tx_done_o  <= txd_next;
      timeout_o  <= to_p_next;
      sync_o     <= sync_next;
      pin_o      <= o_next;
      pin_oe_o   <= oe_next;
    end
  end
endmodule
`default_nettype wire

// >>> sdl_checker.sv
// port-level assertions for the debug link controller
`timescale 1ns/100ps
`default_nettype none
module sdl_checker (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic debug_pin_o,
  input wire logic debug_pin_oe_o,
  input wire logic cpu_abg_i,
  input wire logic req_valid_o,
  input wire logic ack_i,
  input wire logic go_o,
  input wire logic wake_o,
  input wire logic wdog_hold_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);
  sequence zero_low_s;
    (debug_pin_oe_o && !debug_pin_o)[*8] ##1 (debug_pin_oe_o && !debug_pin_o)[*5];
  endsequence
  sequence speedup_s;
    debug_pin_oe_o && debug_pin_o ##1 !debug_pin_oe_o;
  endsequence
  zero_bit_a: assert property ($rose(debug_pin_oe_o) && !debug_pin_o |-> zero_low_s ##1 speedup_s)
    else $error("zero bit drive shape wrong");
  one_pulse_a: assert property ($rose(debug_pin_oe_o) && debug_pin_o |=> !debug_pin_oe_o)
    else $error("one bit pulse too long");
  wdog_hold_a: assert property ($past(rst_b_i) |-> wdog_hold_o == $past(cpu_abg_i))
    else $error("watchdog hold not following background mode");
  go_class_a: assert property (go_o |-> $past(cpu_abg_i))
    else $error("go issued outside background mode");
  go_pulse_a: assert property (go_o |=> !go_o)
    else $error("go longer than one cycle");
  wake_pulse_a: assert property (wake_o |=> !wake_o)
    else $error("wake longer than one cycle");
  req_hold_a: assert property (req_valid_o && !ack_i |=> req_valid_o)
    else $error("access request dropped before ack");
  reset_quiet_a: assert property ($rose(rst_b_i) |-> !debug_pin_oe_o && !go_o)
    else $error("pin driven right after reset");
endmodule
bind sdl_top sdl_checker u_chk (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .debug_pin_o(debug_pin_o),
  .debug_pin_oe_o(debug_pin_oe_o), .cpu_abg_i(cpu_abg_i), .req_valid_o(req_valid_o), .ack_i(ack_i),
  .go_o(go_o), .wake_o(wake_o), .wdog_hold_o(wdog_hold_o));
`default_nettype wire

// >>> sdl_pkg.sv
// shared constants, types and command decode for the single-wire debug link
package sdl_pkg;

  // bit timing, all in debug-clock cycles
  localparam logic [9:0] BIT_CYCLES     = 10'h010;
  localparam logic [9:0] RX_SAMPLE      = 10'h00a;
  localparam logic [9:0] TX1_PULSE      = 10'h007;
  localparam logic [9:0] TX0_LOW        = 10'h00d;
  localparam logic [9:0] TIMEOUT_CYCLES = 10'h200;
  localparam logic [7:0] SYNC_LOW_MIN   = 8'h80;
  localparam logic [9:0] SYNC_DELAY     = 10'h010;
  localparam logic [9:0] SYNC_PULSE     = 10'h080;

  // field widths in bits
  localparam logic [4:0] FW_NONE = 5'h00;
  localparam logic [4:0] FW_BYTE = 5'h08;
  localparam logic [4:0] FW_WORD = 5'h10;

  // status/control byte layout
  localparam int SC_EN_BGND   = 7;
  localparam int SC_BGND_ACT  = 6;
  localparam int SC_BKPT_EN   = 5;
  localparam int SC_FORCE_TAG = 4;
  localparam int SC_CLK_SEL   = 3;
  localparam int SC_WAIT_STOP = 2;

  // command codes
  localparam logic [7:0] CMD_ACK_ON       = 8'hd5;
  localparam logic [7:0] CMD_ACK_OFF      = 8'hd6;
  localparam logic [7:0] CMD_BACKGROUND   = 8'h90;
  localparam logic [7:0] CMD_RD_STATUS    = 8'he4;
  localparam logic [7:0] CMD_WR_CONTROL   = 8'hc4;
  localparam logic [7:0] CMD_RD_BYTE      = 8'he0;
  localparam logic [7:0] CMD_RD_BYTE_WS   = 8'he1;
  localparam logic [7:0] CMD_RD_LAST      = 8'he8;
  localparam logic [7:0] CMD_WR_BYTE      = 8'hc0;
  localparam logic [7:0] CMD_WR_BYTE_WS   = 8'hc1;
  localparam logic [7:0] CMD_RD_BKPT      = 8'he2;
  localparam logic [7:0] CMD_WR_BKPT      = 8'hc2;
  localparam logic [7:0] CMD_GO           = 8'h08;
  localparam logic [7:0] CMD_SINGLE_STEP  = 8'h10;
  localparam logic [7:0] CMD_TAG_GO       = 8'h18;
  localparam logic [7:0] CMD_RD_ACC       = 8'h68;
  localparam logic [7:0] CMD_RD_CCR       = 8'h69;
  localparam logic [7:0] CMD_RD_PC        = 8'h6b;
  localparam logic [7:0] CMD_RD_HX        = 8'h6c;
  localparam logic [7:0] CMD_RD_SP        = 8'h6f;
  localparam logic [7:0] CMD_RD_NEXT      = 8'h70;
  localparam logic [7:0] CMD_RD_NEXT_WS   = 8'h71;
  localparam logic [7:0] CMD_WR_ACC       = 8'h48;
  localparam logic [7:0] CMD_WR_CCR       = 8'h49;
  localparam logic [7:0] CMD_WR_PC        = 8'h4b;
  localparam logic [7:0] CMD_WR_HX        = 8'h4c;
  localparam logic [7:0] CMD_WR_SP        = 8'h4f;
  localparam logic [7:0] CMD_WR_NEXT      = 8'h50;
  localparam logic [7:0] CMD_WR_NEXT_WS   = 8'h51;

  typedef enum logic [1:0] {SDL_ACC_LOCAL, SDL_ACC_MEM, SDL_ACC_CPU} sdl_acc_t;

  typedef struct packed {
    logic       valid;
    logic       intrusive;
    logic       has_addr;
    logic [4:0] wbits;
    logic       ss;
    logic [4:0] rbits;
    sdl_acc_t   acc;
  } sdl_cmd_t;

  // access request to the memory system or the cpu core
  typedef struct packed {
    sdl_acc_t    acc;
    logic        we;
    logic [7:0]  code;
    logic [15:0] addr;
    logic [15:0] wdata;
  } sdl_req_t;

  typedef struct packed {
    logic por;
    logic pin;
    logic err;
  } sdl_rst_cause_t;

  function automatic sdl_cmd_t sdl_fmt(input sdl_acc_t a, input logic intr, input logic ad,
                                       input logic [4:0] w, input logic s, input logic [4:0] r);
    sdl_cmd_t d;
    d = '{valid: 1'b1, intrusive: intr, has_addr: ad, wbits: w, ss: s, rbits: r, acc: a};
    return d;
  endfunction

  function automatic sdl_cmd_t sdl_decode(input logic [7:0] c);
    sdl_cmd_t d;
    d = '0;
    case (c)
      CMD_ACK_ON, CMD_ACK_OFF, CMD_BACKGROUND:
        d = sdl_fmt(SDL_ACC_LOCAL, 1'b0, 1'b0, FW_NONE, 1'b0, FW_NONE);
      CMD_RD_STATUS:   d = sdl_fmt(SDL_ACC_LOCAL, 1'b0, 1'b0, FW_NONE, 1'b1, FW_NONE);
      CMD_WR_CONTROL:  d = sdl_fmt(SDL_ACC_LOCAL, 1'b0, 1'b0, FW_BYTE, 1'b0, FW_NONE);
      CMD_RD_BYTE:     d = sdl_fmt(SDL_ACC_MEM, 1'b0, 1'b1, FW_NONE, 1'b0, FW_BYTE);
      CMD_RD_BYTE_WS:  d = sdl_fmt(SDL_ACC_MEM, 1'b0, 1'b1, FW_NONE, 1'b1, FW_BYTE);
      CMD_RD_LAST:     d = sdl_fmt(SDL_ACC_MEM, 1'b0, 1'b0, FW_NONE, 1'b1, FW_BYTE);
      CMD_WR_BYTE:     d = sdl_fmt(SDL_ACC_MEM, 1'b0, 1'b1, FW_BYTE, 1'b0, FW_NONE);
      CMD_WR_BYTE_WS:  d = sdl_fmt(SDL_ACC_MEM, 1'b0, 1'b1, FW_BYTE, 1'b1, FW_NONE);
      CMD_RD_BKPT:     d = sdl_fmt(SDL_ACC_LOCAL, 1'b0, 1'b0, FW_NONE, 1'b0, FW_WORD);
      CMD_WR_BKPT:     d = sdl_fmt(SDL_ACC_LOCAL, 1'b0, 1'b0, FW_WORD, 1'b0, FW_NONE);
      CMD_GO, CMD_SINGLE_STEP, CMD_TAG_GO:
        d = sdl_fmt(SDL_ACC_LOCAL, 1'b1, 1'b0, FW_NONE, 1'b0, FW_NONE);
      CMD_RD_ACC, CMD_RD_CCR, CMD_RD_NEXT:
        d = sdl_fmt(SDL_ACC_CPU, 1'b1, 1'b0, FW_NONE, 1'b0, FW_BYTE);
      CMD_RD_PC, CMD_RD_HX, CMD_RD_SP:
        d = sdl_fmt(SDL_ACC_CPU, 1'b1, 1'b0, FW_NONE, 1'b0, FW_WORD);
      CMD_RD_NEXT_WS:  d = sdl_fmt(SDL_ACC_CPU, 1'b1, 1'b0, FW_NONE, 1'b1, FW_BYTE);
      CMD_WR_ACC, CMD_WR_CCR, CMD_WR_NEXT:
        d = sdl_fmt(SDL_ACC_CPU, 1'b1, 1'b0, FW_BYTE, 1'b0, FW_NONE);
      CMD_WR_PC, CMD_WR_HX, CMD_WR_SP:
        d = sdl_fmt(SDL_ACC_CPU, 1'b1, 1'b0, FW_WORD, 1'b0, FW_NONE);
      CMD_WR_NEXT_WS:  d = sdl_fmt(SDL_ACC_CPU, 1'b1, 1'b0, FW_BYTE, 1'b1, FW_NONE);
      default:         d = '0;
    endcase
    return d;
  endfunction

endpackage

// >>> sdl_pod.sv
// debug pod model: starts every bit, sends and reads msb first
`timescale 1ns/100ps
`default_nettype none
module sdl_pod (
  input  wire logic ref_clk_i,
  input  wire logic line_i,
  output logic      drv_en_o,
  output logic      drv_o
);
  initial drv_en_o = 1'b1;
  initial drv_o = 1'b1;
  task automatic edge_n(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask
  // zeros held low past the target sample point, highs driven actively
  task automatic send(input logic [15:0] d, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      drv_o = 1'b0;
      edge_n(d[i] ? 4 : 15);
      drv_o = 1'b1;
      edge_n(d[i] ? 14 : 3);
    end
  endtask
  task automatic recv(output logic [15:0] d, input int n);
    d = '0;
    for (int i = n - 1; i >= 0; i--) begin
      drv_en_o = 1'b1;
      drv_o = 1'b0;
      // held low until the target has taken over a zero, released before a one pulse
      edge_n(6);
      drv_en_o = 1'b0;
      edge_n(6);
      d[i] = line_i;
      edge_n(8);
    end
    drv_o = 1'b1;
    drv_en_o = 1'b1;
    edge_n(1);
  endtask
  task automatic level(input logic l);
    drv_o = l;
  endtask
endmodule
`default_nettype wire

// >>> sdl_top.sv
// single-wire debug link controller, target side
`timescale 1ns/100ps
`default_nettype none
module sdl_top #(
  parameter logic [15:0] FORCE_RST_REG_ADDR = 16'h1800,
  parameter int          FORCE_RST_BIT      = 0
) (
  // clock and reset
  input  wire logic                    ref_clk_i,
  input  wire logic                    rst_b_i,
  // debug pin and alternate debug clock
  input  wire logic                    debug_pin_i,
  output logic                         debug_pin_o,
  output logic                         debug_pin_oe_o,
  input  wire logic                    alt_dbg_clk_i,
  // system reset status
  input  wire logic                    sys_rst_active_i,
  input  wire sdl_pkg::sdl_rst_cause_t rst_cause_i,
  // cpu state
  input  wire logic                    cpu_abg_i,
  input  wire logic                    cpu_low_pwr_i,
  input  wire logic [15:0]             cpu_addr_i,
  input  wire logic                    cpu_addr_valid_i,
  // access port to memory and cpu
  output logic                         req_valid_o,
  output sdl_pkg::sdl_req_t            req_o,
  input  wire logic                    ack_i,
  input  wire logic [15:0]             rdata_i,
  // control outputs
  output logic                         abg_enter_o,
  output logic                         wake_o,
  output logic                         go_o,
  output logic                         step_o,
  output logic                         sys_reset_req_o,
  output logic                         osc_keep_o,
  output logic                         wdog_hold_o,
  output logic                         bkpt_hit_o
);
  typedef enum logic [2:0] {ST_CMD, ST_ADDR, ST_WDATA, ST_EXEC, ST_STAT, ST_RDATA} sdl_st_t;

  // three-stage filter: a change is accepted once stages two and three agree
  function automatic logic sdl_filt(input logic cur, input logic [2:0] s);
    return (s[1] == s[2]) ? s[2] : cur;
  endfunction

  logic [2:0] pin_s_reg, alt_s_reg;
  logic       pin_lvl_reg, pin_lvl_next, alt_lvl_reg, alt_lvl_next;
  logic       pin_fall, pin_rise, tick;

  always_comb begin
    pin_lvl_next = sdl_filt(pin_lvl_reg, pin_s_reg);
    alt_lvl_next = sdl_filt(alt_lvl_reg, alt_s_reg);
  end

  // pull-up level is the reset value, so an open pin reads high
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      pin_s_reg   <= 3'h7;
      pin_lvl_reg <= 1'b1;
      alt_s_reg   <= 3'h0;
      alt_lvl_reg <= 1'b0;
    end else begin
      pin_s_reg   <= {pin_s_reg[1:0], debug_pin_i};
      pin_lvl_reg <= pin_lvl_next;
      alt_s_reg   <= {alt_s_reg[1:0], alt_dbg_clk_i};
      alt_lvl_reg <= alt_lvl_next;
    end
  end

  logic [7:0] scr_reg, scr_next;
  assign pin_fall = pin_lvl_reg & ~pin_lvl_next;
  assign pin_rise = ~pin_lvl_reg & pin_lvl_next;
  // alternate source is only usable below a quarter of ref_clk_i
  assign tick     = scr_reg[sdl_pkg::SC_CLK_SEL] ? (~alt_lvl_reg & alt_lvl_next) : 1'b1;

  logic rx_valid, rx_bit, tx_done, timeout, sync_req, tx_mode, tx_bit;

  sdl_bit_engine u_engine (
    .ref_clk_i  (ref_clk_i),
    .rst_b_i    (rst_b_i),
    .tick_i     (tick),
    .pin_lvl_i  (pin_lvl_reg),
    .pin_fall_i (pin_fall),
    .pin_rise_i (pin_rise),
    .tx_mode_i  (tx_mode),
    .tx_bit_i   (tx_bit),
    .rx_valid_o (rx_valid),
    .rx_bit_o   (rx_bit),
    .tx_done_o  (tx_done),
    .timeout_o  (timeout),
    .sync_o     (sync_req),
    .pin_o      (debug_pin_o),
    .pin_oe_o   (debug_pin_oe_o)
  );

  sdl_st_t           st_reg, st_next;
  sdl_pkg::sdl_cmd_t cmd_reg, cmd_next, dec;
  logic [7:0]        code_reg, code_next;
  logic [15:0]       sh_reg, sh_next;
  logic [4:0]        bcnt_reg, bcnt_next;
  logic [15:0]       addr_reg, addr_next, last_reg, last_next, wd_reg, wd_next, bkpt_reg, bkpt_next;
  sdl_pkg::sdl_req_t req_reg, req_next;
  logic              force_reg, force_next, srst_reg, hit_next;
  logic              enter_next, wake_next, go_next, step_next, sreq_next;
  logic [15:0]       sh_in;
  logic [7:0]        status;

  assign sh_in   = {sh_reg[14:0], rx_bit};
  assign dec     = sdl_pkg::sdl_decode(sh_in[7:0]);
  assign status  = {scr_reg[7], cpu_abg_i, scr_reg[5:3], cpu_low_pwr_i, 2'b00};
  assign tx_mode = (st_reg == ST_STAT) || (st_reg == ST_RDATA);
  assign tx_bit  = sh_reg[15];
  assign req_valid_o = (st_reg == ST_EXEC) && (cmd_reg.acc != sdl_pkg::SDL_ACC_LOCAL);
  assign req_o   = req_reg;

  always_comb begin
    st_next    = st_reg;
    cmd_next   = cmd_reg;
    code_next  = code_reg;
    sh_next    = sh_reg;
    bcnt_next  = bcnt_reg;
    addr_next  = addr_reg;
    last_next  = last_reg;
    wd_next    = wd_reg;
    bkpt_next  = bkpt_reg;
    scr_next   = scr_reg;
    req_next   = req_reg;
    force_next = force_reg;
    enter_next = 1'b0;
    wake_next  = 1'b0;
    go_next    = 1'b0;
    step_next  = 1'b0;
    sreq_next  = 1'b0;
    hit_next   = scr_reg[sdl_pkg::SC_BKPT_EN] && cpu_addr_valid_i && cpu_addr_i == bkpt_reg;
    case (st_reg)
      ST_CMD: if (rx_valid) begin
        sh_next   = sh_in;
        bcnt_next = bcnt_reg + 5'h01;
        if (bcnt_reg == sdl_pkg::FW_BYTE - 5'h01) begin
          bcnt_next = '0;
          cmd_next  = dec;
          code_next = sh_in[7:0];
          // core commands outside background mode are dropped
          if (!dec.valid || (dec.intrusive && !cpu_abg_i)) begin
            st_next = ST_CMD;
          end else if (dec.has_addr) begin
            st_next = ST_ADDR;
          end else if (dec.wbits != sdl_pkg::FW_NONE) begin
            st_next = ST_WDATA;
          end else begin
            st_next = ST_EXEC;
          end
        end
      end
      ST_ADDR: if (rx_valid) begin
        sh_next   = sh_in;
        bcnt_next = bcnt_reg + 5'h01;
        if (bcnt_reg == sdl_pkg::FW_WORD - 5'h01) begin
          bcnt_next = '0;
          addr_next = sh_in;
          st_next   = (cmd_reg.wbits != sdl_pkg::FW_NONE) ? ST_WDATA : ST_EXEC;
        end
      end
      ST_WDATA: if (rx_valid) begin
        sh_next   = sh_in;
        bcnt_next = bcnt_reg + 5'h01;
        if (bcnt_reg == cmd_reg.wbits - 5'h01) begin
          bcnt_next = '0;
          wd_next   = sh_in;
          st_next   = ST_EXEC;
        end
      end
      ST_EXEC: begin
        req_next = '{acc: cmd_reg.acc, we: cmd_reg.wbits != sdl_pkg::FW_NONE, code: code_reg,
                     addr: (code_reg == sdl_pkg::CMD_RD_LAST) ? last_reg : addr_reg, wdata: wd_reg};
        if (cmd_reg.acc == sdl_pkg::SDL_ACC_LOCAL || ack_i) begin
          sh_next = rdata_i;
          case (code_reg)
            sdl_pkg::CMD_BACKGROUND: begin
              enter_next = scr_reg[sdl_pkg::SC_EN_BGND];
              wake_next  = scr_reg[sdl_pkg::SC_EN_BGND];
            end
            sdl_pkg::CMD_WR_CONTROL: scr_next = wd_reg[7:0];
            sdl_pkg::CMD_WR_BKPT:    bkpt_next = wd_reg;
            sdl_pkg::CMD_RD_BKPT:    sh_next = bkpt_reg;
            sdl_pkg::CMD_GO, sdl_pkg::CMD_TAG_GO: go_next = 1'b1;
            sdl_pkg::CMD_SINGLE_STEP: step_next = 1'b1;
            default: sh_next = rdata_i;
          endcase
          if (cmd_reg.acc == sdl_pkg::SDL_ACC_MEM) begin
            last_next = req_reg.addr;
          end
          if (cmd_reg.acc == sdl_pkg::SDL_ACC_MEM && req_reg.we && req_reg.addr == FORCE_RST_REG_ADDR
              && req_reg.wdata[FORCE_RST_BIT]) begin
            force_next = 1'b1;
            sreq_next  = 1'b1;
          end
          if (cmd_reg.rbits == sdl_pkg::FW_BYTE) begin
            sh_next = {sh_next[7:0], 8'h00};
          end
          if (cmd_reg.ss) begin
            st_next = ST_STAT;
          end else begin
            st_next = (cmd_reg.rbits != sdl_pkg::FW_NONE) ? ST_RDATA : ST_CMD;
          end
          // status goes out first, data waits in the low byte
          if (cmd_reg.ss) begin
            sh_next = {status, sh_next[15:8]};
          end
        end
      end
      ST_STAT, ST_RDATA: if (tx_done) begin
        sh_next   = {sh_reg[14:0], 1'b0};
        bcnt_next = bcnt_reg + 5'h01;
        if (st_reg == ST_STAT && bcnt_reg == sdl_pkg::FW_BYTE - 5'h01) begin
          bcnt_next = '0;
          st_next   = (cmd_reg.rbits != sdl_pkg::FW_NONE) ? ST_RDATA : ST_CMD;
        end else if (st_reg == ST_RDATA && bcnt_reg == cmd_reg.rbits - 5'h01) begin
          bcnt_next = '0;
          st_next   = ST_CMD;
        end
      end
      default: st_next = ST_CMD;
    endcase
    // abort leaves memory and mode untouched: only the parser is cleared
    if (timeout || sync_req) begin
      st_next   = ST_CMD;
      bcnt_next = '0;
    end
    // reset-end mode choice; pin and error resets force background only after a force write
    if (srst_reg && !sys_rst_active_i) begin
      // a force write landing in the same cycle as reset end wins over the clear
      force_next = sreq_next;
      if ((rst_cause_i.por || force_reg) && !pin_lvl_reg) begin
        enter_next = 1'b1;
        scr_next[sdl_pkg::SC_EN_BGND] = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      st_reg          <= ST_CMD;
      cmd_reg         <= '0;
      code_reg        <= 8'h00;
      sh_reg          <= 16'h0000;
      bcnt_reg        <= 5'h00;
      addr_reg        <= 16'h0000;
      last_reg        <= 16'h0000;
      wd_reg          <= 16'h0000;
      bkpt_reg        <= 16'h0000;
      scr_reg         <= 8'h00;
      req_reg         <= '0;
      force_reg       <= 1'b0;
      srst_reg        <= 1'b0;
      abg_enter_o     <= 1'b0;
      wake_o          <= 1'b0;
      go_o            <= 1'b0;
      step_o          <= 1'b0;
      sys_reset_req_o <= 1'b0;
      osc_keep_o      <= 1'b0;
      wdog_hold_o     <= 1'b0;
      bkpt_hit_o      <= 1'b0;
    end else begin
      st_reg          <= st_next;
      cmd_reg         <= cmd_next;
      code_reg        <= code_next;
      sh_reg          <= sh_next;
      bcnt_reg        <= bcnt_next;
      addr_reg        <= addr_next;
      last_reg        <= last_next;
      wd_reg          <= wd_next;
      bkpt_reg        <= bkpt_next;
      scr_reg         <= scr_next;
      req_reg         <= req_next;
      force_reg       <= force_next;
      srst_reg        <= sys_rst_active_i;
      abg_enter_o     <= enter_next;
      wake_o          <= wake_next;
      go_o            <= go_next;
      step_o          <= step_next;
      sys_reset_req_o <= sreq_next;
      osc_keep_o      <= scr_next[sdl_pkg::SC_EN_BGND];
      wdog_hold_o     <= cpu_abg_i;
      bkpt_hit_o      <= hit_next;
    end
  end
endmodule
`default_nettype wire

// >>> single_wire_debug_link_tb_top.sv
// self-checking bench for the debug link controller
`timescale 1ns/100ps
`default_nettype none
module single_wire_debug_link_tb_top;
  logic ref_clk_i, rst_b_i, cpu_abg_i, cpu_low_pwr_i, ack_i, debug_pin_o, debug_pin_oe_o, req_valid_o;
  logic go_o, wake_o, osc_keep_o, wdog_hold_o, en, drv;
  logic sys_rst, bk_v, enter, step, hit;
  logic [15:0] bk_a;
  sdl_pkg::sdl_rst_cause_t cause;
  logic [3:0] seen;
  logic [15:0] v;
  sdl_pkg::sdl_req_t req_o;
  int n_errors = 0;
  int samples_checked = 0;
  // pull-up when nobody drives
  wire logic debug_pin_i = debug_pin_oe_o ? debug_pin_o : (en ? drv : 1'b1);
  sdl_top dut (.ref_clk_i, .rst_b_i, .debug_pin_i, .debug_pin_o, .debug_pin_oe_o, .alt_dbg_clk_i(1'b0),
    .sys_rst_active_i(sys_rst), .rst_cause_i(cause), .cpu_abg_i, .cpu_low_pwr_i, .cpu_addr_i(bk_a),
    .cpu_addr_valid_i(bk_v), .req_valid_o, .req_o, .ack_i, .rdata_i(v), .abg_enter_o(enter), .wake_o, .go_o,
    .step_o(step), .sys_reset_req_o(), .osc_keep_o, .wdog_hold_o, .bkpt_hit_o(hit));
  sdl_pod pod (.ref_clk_i, .line_i(debug_pin_i), .drv_en_o(en), .drv_o(drv));
  always @(posedge ref_clk_i) seen <= seen | {enter, step, go_o, wake_o};
  task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic end_sim;
    $display("mismatches %0d comparisons %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic t_status(input logic [7:0] e);
    pod.send({8'h00, sdl_pkg::CMD_RD_STATUS}, 8);
    pod.recv(v, 8);
    chk("status", {8'h00, e}, v);
  endtask
  task automatic t_cmd(input logic [7:0] c, input logic [3:0] e);
    seen = '0;
    pod.send({8'h00, c}, 8);
    pod.edge_n(20);
    chk("go and wake", {12'h0, e}, {12'h0, seen});
  endtask
  // pin low across reset end, no force write: only a power-on reset forces background
  task automatic t_rst(input logic [2:0] c, input logic [3:0] e);
    seen = '0;
    cause = c;
    sys_rst = 1'b1;
    pod.level(1'b0);
    pod.edge_n(6);
    sys_rst = 1'b0;
    pod.edge_n(4);
    pod.level(1'b1);
    pod.edge_n(600);
    chk("reset entry", {12'h0, e}, {12'h0, seen});
  endtask
  task automatic t_bkpt;
    pod.send({8'h00, sdl_pkg::CMD_WR_BKPT}, 8);
    pod.send(16'h4321, 16);
    pod.send({sdl_pkg::CMD_WR_CONTROL, 8'ha0}, 16);
    pod.edge_n(20);
    bk_a = 16'h4320;
    bk_v = 1'b1;
    pod.edge_n(1);
    chk("breakpoint miss", 16'h0000, {15'h0, hit});
    bk_a = 16'h4321;
    pod.edge_n(1);
    chk("breakpoint hit", 16'h0001, {15'h0, hit});
    bk_v = 1'b0;
  endtask
  // a stalled half command must be dropped before the read is accepted
  task automatic t_mem;
    pod.send(16'h000e, 4);
    pod.edge_n(600);
    pod.send({sdl_pkg::CMD_RD_BYTE, 8'h12}, 16);
    pod.send(16'h0034, 8);
    for (int i = 0; i < 60 && req_valid_o !== 1'b1; i++) pod.edge_n(1);
    // the request word settles one cycle after valid rises
    pod.edge_n(1);
    chk("address", 16'h1234, req_o.addr);
    v = 16'h005a;
    ack_i = 1'b1;
    pod.edge_n(1);
    ack_i = 1'b0;
    pod.edge_n(16);
    pod.recv(v, 8);
    chk("read data", 16'h005a, v);
  endtask
  initial begin
    ref_clk_i = 1'b0;
    forever #2 ref_clk_i = ~ref_clk_i;
  end
  initial begin
    #100000;
    n_errors++;
    end_sim;
  end
  initial begin
    rst_b_i = 1'b0;
    cpu_abg_i = 1'b1;
    cpu_low_pwr_i = 1'b1;
    ack_i = 1'b0;
    v = '0;
    seen = '0;
    sys_rst = 1'b0;
    cause = '0;
    bk_a = '0;
    bk_v = 1'b0;
    repeat (3) @(posedge ref_clk_i);
    #1;
    rst_b_i = 1'b1;
    pod.edge_n(1);
    chk("idle drive", 16'h0000, {15'h0, debug_pin_oe_o});
    pod.edge_n(8);
    t_status(8'h44);
    pod.send({sdl_pkg::CMD_WR_CONTROL, 8'h80}, 16);
    t_status(8'hc4);
    chk("osc keep", 16'h0001, {15'h0, osc_keep_o});
    cpu_abg_i = 1'b0;
    t_cmd(sdl_pkg::CMD_GO, 4'h0);
    t_cmd(sdl_pkg::CMD_BACKGROUND, 4'h9);
    cpu_abg_i = 1'b1;
    t_cmd(sdl_pkg::CMD_GO, 4'h2);
    t_cmd(sdl_pkg::CMD_SINGLE_STEP, 4'h4);
    t_bkpt;
    t_rst(3'h4, 4'h8);
    t_rst(3'h2, 4'h0);
    chk("watchdog hold", 16'h0001, {15'h0, wdog_hold_o});
    t_mem;
    end_sim;
  end
endmodule
`default_nettype wire
